// ### core/framer_pkg.sv
// Constants, state types and the checksum step shared by the group framer.
// Assumes one system clock; the serial link is sampled, never used as a clock.
package framer_pkg;
    localparam logic [7:0]  LEN_MIN         = 8'h04;
    localparam logic [7:0]  LEN_MAX         = 8'h9B;
    localparam logic [7:0]  CRC_LSB_BACK    = 8'h02;
    localparam logic [7:0]  CRC_MSB_BACK    = 8'h01;
    localparam logic [7:0]  FRAME_OVERHEAD  = 8'h03;
    localparam logic [7:0]  PACKET_FIRST    = 8'h01;
    localparam logic [7:0]  STATUS_COMM_ERR = 8'hFF;
    localparam logic [15:0] CRC_POLY        = 16'h8005;
    localparam logic [15:0] CRC_INIT        = 16'h0000;
    localparam logic [3:0]  BIT_LAST        = 4'h8;
    localparam logic [3:0]  BIT_ACK         = 4'h9;
    localparam logic [7:0]  IDX_OPCODE      = 8'h00;
    localparam logic [7:0]  IDX_FIRST_PARAM = 8'h01;
    localparam logic [7:0]  IDX_SECOND_LO   = 8'h02;
    localparam logic [7:0]  IDX_SECOND_HI   = 8'h03;

    typedef enum logic [2:0] {
        F_IDLE  = 3'b000, F_BODY = 3'b001, F_CHECK = 3'b011, F_EXEC = 3'b010,
        F_BUILD = 3'b110, F_CRCL = 3'b111, F_CRCH  = 3'b101
    } frame_state_t;

    typedef enum logic [2:0] {
        L_IDLE = 3'b000, L_ADDR = 3'b001, L_WRITE = 3'b011, L_READ = 3'b010, L_SKIP = 3'b110
    } link_state_t;

    // Bits enter least significant first, register shifts toward the top
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (data[i] ^ c[15]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc_byte
endpackage : framer_pkg

// ### core/byte_fifo.sv
// Small synchronous FIFO between the serial byte receiver and the framer.
// Assumes both sides on clk_in; flush_in empties it in one cycle.
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             flush_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;

    assign rd_valid_out = (wr_ptr_q != rd_ptr_q);
    assign wr_ready_out = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]) || (wr_ptr_q[AW] == rd_ptr_q[AW]);
    assign rd_data_out  = mem[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (wr_valid_in && wr_ready_out) begin
            mem[wr_ptr_q[AW-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || flush_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (wr_valid_in && wr_ready_out) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (rd_valid_out && rd_ready_in) rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule : byte_fifo

// ### core/command_group_framer.sv
// Serial target that receives command groups, checks them and frames responses.
// Assumes the executor sits on clk_in and the bus pins arrive unsynchronised.
`timescale 1ns/100ps
module command_group_framer #(
    parameter logic [6:0] TARGET_ADDR = 7'h60,
    parameter int         FIFO_DEPTH  = 16,
    parameter int         BUF_BYTES   = 155
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       sleep_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out_out,
    output logic            sda_oe_out,
    output logic            busy_out,
    output logic            cmd_valid_out,
    output logic [7:0]      cmd_count_out,
    output logic [7:0]      opcode_out,
    output logic [7:0]      first_parameter_out,
    output logic [15:0]     second_parameter_out,
    input  wire logic [7:0] cmd_addr_in,
    output logic [7:0]      cmd_data_out,
    input  wire logic       res_wr_in,
    input  wire logic [7:0] res_byte_in,
    input  wire logic       res_done_in
);
    framer_pkg::frame_state_t f_state_q;
    framer_pkg::link_state_t  l_state_q;

    logic [7:0]  cmd_mem [BUF_BYTES];
    logic [7:0]  resp_mem [BUF_BYTES];
    logic [2:0]  scl_sync_q;
    logic [2:0]  sda_sync_q;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        sda_rise;
    logic        sda_fall;
    logic [3:0]  bit_q;
    logic [7:0]  rx_sh_q;
    logic [7:0]  tx_sh_q;
    logic        oe_q;
    logic        host_ack_q;
    logic [7:0]  rd_idx_q;
    logic        push_q;
    logic        fifo_ready;
    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        pop;
    logic        res_take;
    logic        busy;
    logic [7:0]  len_q;
    logic [7:0]  cnt_q;
    logic [15:0] crc_q;
    logic [15:0] rx_crc_q;
    logic        err_q;
    logic        resp_ok_q;
    logic [7:0]  resp_len_q;
    logic [7:0]  wr_idx_q;
    logic [7:0]  b_idx_q;
    logic [7:0]  build_byte;
    logic        cmd_valid_q;
    logic [7:0]  cmd_data_q;
    logic [7:0]  opcode_q;
    logic [7:0]  first_param_q;
    logic [15:0] second_param_q;

    // Pin sampling: a level counts once the second and third stages agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
            if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
            if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
        end
    end

    assign scl_rise = (scl_sync_q[1] == scl_sync_q[2]) && scl_sync_q[2] && !scl_q;
    assign scl_fall = (scl_sync_q[1] == scl_sync_q[2]) && !scl_sync_q[2] && scl_q;
    assign sda_rise = (sda_sync_q[1] == sda_sync_q[2]) && sda_sync_q[2] && !sda_q;
    assign sda_fall = (sda_sync_q[1] == sda_sync_q[2]) && !sda_sync_q[2] && sda_q;

    assign busy = (f_state_q == framer_pkg::F_CHECK) || (f_state_q == framer_pkg::F_EXEC) ||
                  (f_state_q == framer_pkg::F_BUILD) || (f_state_q == framer_pkg::F_CRCL) ||
                  (f_state_q == framer_pkg::F_CRCH);

    // Open drain: the pin is only ever pulled low, never driven high
    assign sda_out_out = 1'b0;
    assign sda_oe_out  = oe_q;
    assign busy_out    = busy;

    // Link engine; writes carry commands, reads carry answers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || sleep_in) begin
            l_state_q  <= framer_pkg::L_IDLE;
            bit_q      <= '0;
            rx_sh_q    <= '0;
            tx_sh_q    <= '0;
            oe_q       <= 1'b0;
            host_ack_q <= 1'b0;
            rd_idx_q   <= '0;
            push_q     <= 1'b0;
        end else if (busy) begin
            l_state_q <= framer_pkg::L_IDLE;
            oe_q      <= 1'b0;
            push_q    <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (scl_q && sda_fall) begin
                l_state_q <= framer_pkg::L_ADDR;
                bit_q     <= '0;
                oe_q      <= 1'b0;
            end else if (scl_q && sda_rise) begin
                l_state_q <= framer_pkg::L_IDLE;
                oe_q      <= 1'b0;
            end else if (l_state_q == framer_pkg::L_IDLE || l_state_q == framer_pkg::L_SKIP) begin
                oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (bit_q < framer_pkg::BIT_LAST) rx_sh_q <= {rx_sh_q[6:0], sda_q};
                if (bit_q == framer_pkg::BIT_LAST) host_ack_q <= !sda_q;
                bit_q <= bit_q + 4'h1;
            end else if (scl_fall) begin
                case (bit_q)
                    framer_pkg::BIT_LAST: begin
                        oe_q <= 1'b0;
                        case (l_state_q)
                            framer_pkg::L_ADDR: begin
                                if (rx_sh_q[7:1] != TARGET_ADDR) begin
                                    l_state_q <= framer_pkg::L_SKIP;
                                end else if (!rx_sh_q[0]) begin
                                    l_state_q <= framer_pkg::L_WRITE;
                                    oe_q      <= 1'b1;
                                end else if (resp_ok_q && f_state_q == framer_pkg::F_IDLE) begin
                                    l_state_q  <= framer_pkg::L_READ;
                                    oe_q       <= 1'b1;
                                    host_ack_q <= 1'b1;
                                    rd_idx_q   <= '0;
                                end else begin
                                    l_state_q <= framer_pkg::L_SKIP;
                                end
                            end
                            framer_pkg::L_WRITE: begin
                                // A full queue refuses the byte so the host sees back-pressure
                                if (fifo_ready) begin
                                    push_q <= 1'b1;
                                    oe_q   <= 1'b1;
                                end else begin
                                    l_state_q <= framer_pkg::L_SKIP;
                                end
                            end
                            default: ;
                        endcase
                    end
                    framer_pkg::BIT_ACK: begin
                        bit_q <= '0;
                        oe_q  <= 1'b0;
                        if (l_state_q == framer_pkg::L_READ) begin
                            if (host_ack_q) begin
                                tx_sh_q  <= resp_mem[rd_idx_q];
                                oe_q     <= !resp_mem[rd_idx_q][7];
                                rd_idx_q <= rd_idx_q + 8'h01;
                            end else begin
                                l_state_q <= framer_pkg::L_SKIP;
                            end
                        end
                    end
                    default: begin
                        if (l_state_q == framer_pkg::L_READ) begin
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                            oe_q    <= !tx_sh_q[6];
                        end
                    end
                endcase
            end
        end
    end

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .flush_in     (sleep_in),
        .wr_valid_in  (push_q),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (rx_sh_q),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  ((f_state_q == framer_pkg::F_IDLE) || (f_state_q == framer_pkg::F_BODY)),
        .rd_data_out  (fifo_data)
    );
    assign pop = fifo_valid &&
                 ((f_state_q == framer_pkg::F_IDLE) || (f_state_q == framer_pkg::F_BODY));
    assign build_byte = (b_idx_q == '0) ? resp_len_q : resp_mem[b_idx_q];
    assign res_take   = res_wr_in && (wr_idx_q < framer_pkg::LEN_MAX - framer_pkg::CRC_LSB_BACK);
    // Group receiver, checker and answer builder
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || sleep_in) begin
            f_state_q   <= framer_pkg::F_IDLE;
            resp_ok_q   <= 1'b0;
            len_q       <= '0;
            cnt_q       <= '0;
            crc_q       <= framer_pkg::CRC_INIT;
            rx_crc_q    <= '0;
            err_q       <= 1'b0;
            resp_len_q  <= '0;
            wr_idx_q    <= '0;
            b_idx_q     <= '0;
            cmd_valid_q <= 1'b0;
        end else begin
            cmd_valid_q <= 1'b0;
            case (f_state_q)
                framer_pkg::F_IDLE: begin
                    if (pop) begin
                        len_q     <= fifo_data;
                        cnt_q     <= 8'h01;
                        crc_q <= framer_pkg::crc_byte(framer_pkg::CRC_INIT, fifo_data);
                        resp_ok_q <= 1'b0;
                        err_q     <= (fifo_data < framer_pkg::LEN_MIN) ||
                                     (fifo_data > framer_pkg::LEN_MAX);
                        if ((fifo_data < framer_pkg::LEN_MIN) || (fifo_data > framer_pkg::LEN_MAX))
                            f_state_q <= framer_pkg::F_CHECK;
                        else
                            f_state_q <= framer_pkg::F_BODY;
                    end
                end
                framer_pkg::F_BODY: begin
                    if (pop) begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q < len_q - framer_pkg::CRC_LSB_BACK) begin
                            cmd_mem[cnt_q - framer_pkg::PACKET_FIRST] <= fifo_data;
                            crc_q <= framer_pkg::crc_byte(crc_q, fifo_data);
                        end else if (cnt_q == len_q - framer_pkg::CRC_LSB_BACK) begin
                            rx_crc_q[7:0] <= fifo_data;
                        end else begin
                            rx_crc_q[15:8] <= fifo_data;
                        end
                        if (cnt_q == len_q - framer_pkg::CRC_MSB_BACK)
                            f_state_q <= framer_pkg::F_CHECK;
                    end
                end
                framer_pkg::F_CHECK: begin
                    if (err_q || (rx_crc_q != crc_q)) begin
                        resp_mem[framer_pkg::PACKET_FIRST] <= framer_pkg::STATUS_COMM_ERR;
                        resp_len_q <= framer_pkg::LEN_MIN;
                        b_idx_q    <= '0;
                        crc_q      <= framer_pkg::CRC_INIT;
                        f_state_q  <= framer_pkg::F_BUILD;
                    end else begin
                        cmd_valid_q <= 1'b1;
                        wr_idx_q    <= framer_pkg::PACKET_FIRST;
                        f_state_q   <= framer_pkg::F_EXEC;
                    end
                end
                framer_pkg::F_EXEC: begin
                    if (res_take) begin
                        resp_mem[wr_idx_q] <= res_byte_in;
                        wr_idx_q <= wr_idx_q + 8'h01;
                    end
                    if (res_done_in) begin
                        resp_len_q <= wr_idx_q + framer_pkg::CRC_LSB_BACK + {7'h00, res_take};
                        b_idx_q    <= '0;
                        crc_q      <= framer_pkg::CRC_INIT;
                        f_state_q  <= framer_pkg::F_BUILD;
                    end
                end
                framer_pkg::F_BUILD: begin
                    if (b_idx_q == '0) resp_mem[0] <= resp_len_q;
                    crc_q   <= framer_pkg::crc_byte(crc_q, build_byte);
                    b_idx_q <= b_idx_q + 8'h01;
                    if (b_idx_q == resp_len_q - framer_pkg::FRAME_OVERHEAD)
                        f_state_q <= framer_pkg::F_CRCL;
                end
                framer_pkg::F_CRCL: begin
                    resp_mem[resp_len_q - framer_pkg::CRC_LSB_BACK] <= crc_q[7:0];
                    f_state_q <= framer_pkg::F_CRCH;
                end
                framer_pkg::F_CRCH: begin
                    resp_mem[resp_len_q - framer_pkg::CRC_MSB_BACK] <= crc_q[15:8];
                    resp_ok_q <= 1'b1;
                    f_state_q <= framer_pkg::F_IDLE;
                end
                default: f_state_q <= framer_pkg::F_IDLE;
            endcase
        end
    end

    // Command fields for the executor; only device logic sees the buffers
    always_ff @(posedge clk_in) begin
        cmd_data_q <= cmd_mem[cmd_addr_in];
        if (f_state_q == framer_pkg::F_CHECK) begin
            opcode_q       <= cmd_mem[framer_pkg::IDX_OPCODE];
            first_param_q  <= cmd_mem[framer_pkg::IDX_FIRST_PARAM];
            second_param_q <= {cmd_mem[framer_pkg::IDX_SECOND_HI],
                               cmd_mem[framer_pkg::IDX_SECOND_LO]};
        end
    end

    assign cmd_valid_out        = cmd_valid_q;
    assign cmd_count_out        = len_q;
    assign opcode_out           = opcode_q;
    assign first_parameter_out  = first_param_q;
    assign second_parameter_out = second_param_q;
    assign cmd_data_out         = cmd_data_q;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_busy_after_last: assert property (
        (f_state_q == framer_pkg::F_BODY && pop && !sleep_in &&
         cnt_q == len_q - framer_pkg::CRC_MSB_BACK) |=> busy)
        else $error("not busy after last group byte");
    a_len_out_range: assert property (
        (f_state_q == framer_pkg::F_IDLE && pop && !sleep_in &&
         fifo_data > framer_pkg::LEN_MAX) |=> (f_state_q == framer_pkg::F_CHECK) ##1
        (f_state_q == framer_pkg::F_BUILD && resp_len_q == framer_pkg::LEN_MIN))
        else $error("bad count not answered with error group");
    a_crc_zero_start: assert property (
        (f_state_q == framer_pkg::F_IDLE && pop && !sleep_in) |=>
        crc_q == framer_pkg::crc_byte(16'h0000, $past(fifo_data)))
        else $error("checksum not restarted from zero");
    a_crc_low_first: assert property (
        (f_state_q == framer_pkg::F_CRCL && !sleep_in) |=>
        resp_mem[resp_len_q - framer_pkg::CRC_LSB_BACK] == $past(crc_q[7:0]))
        else $error("checksum low byte misplaced");
    a_busy_ignore_link: assert property (
        (busy && $past(busy)) |-> (!oe_q && l_state_q == framer_pkg::L_IDLE && !push_q))
        else $error("link active while busy");
    a_bad_not_exec: assert property (
        (f_state_q == framer_pkg::F_CHECK && rx_crc_q != crc_q && !sleep_in) |=>
        (!cmd_valid_q && f_state_q == framer_pkg::F_BUILD) ##1
        (resp_mem[framer_pkg::PACKET_FIRST] == framer_pkg::STATUS_COMM_ERR))
        else $error("failed group executed or not flagged");
    a_sleep_invalid: assert property (
        sleep_in |=> (!resp_ok_q && f_state_q == framer_pkg::F_IDLE && !fifo_valid))
        else $error("buffers survive sleep");
    a_busy_exit_ready: assert property (
        $fell(busy) |-> (resp_ok_q || $past(sleep_in)))
        else $error("busy left without buffered answer");
    a_no_read_busy: assert property (
        (l_state_q == framer_pkg::L_READ) |-> (resp_ok_q && !busy))
        else $error("read served without valid answer");
    a_count_bytes: assert property (
        (f_state_q == framer_pkg::F_BODY) |-> (cnt_q < len_q))
        else $error("collected more than count bytes");
endmodule : command_group_framer

// ### bench/host_bus_model.sv
// Host controller model for the serial link: makes the clock, pulls data low.
// Assumes the bench resolves the data wire with a pull-up and feeds it back.
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_pull_out
);
    // Clock idles high between frames, no free running
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    task automatic quarter();
        repeat (4) @(negedge clk_in);
    endtask : quarter
    // One 160 ns bit slot; data only moves while the clock is low
    task automatic bit_slot(input logic b, output logic s);
        scl_out = 1'b0;
        quarter();
        sda_pull_out = ~b;
        quarter();
        scl_out = 1'b1;
        quarter();
        s = sda_in;
        quarter();
    endtask : bit_slot
    task automatic start_bit();
        quarter();
        sda_pull_out = 1'b1;
        quarter();
    endtask : start_bit
    task automatic stop_bit();
        // Data is pulled low while the clock is low, so no false start; its release with the clock high is the stop
        scl_out = 1'b0;
        quarter();
        sda_pull_out = 1'b1;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_pull_out = 1'b0;
        quarter();
    endtask : stop_bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask : send_byte
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            b[i] = s;
        end
        bit_slot(~more, s);
    endtask : get_byte
endmodule : host_bus_model

// ### bench/tb_command_group_framer.sv
// Self-checking bench: host model on the link, bench acts as executor.
// Assumes the data wire has a pull-up; all inputs move on the falling edge.
`timescale 1ns/100ps
module tb_command_group_framer;
    localparam logic [6:0] ADDR = 7'h60;
    logic        clk_in, rst_n_in, sleep_in, scl, pull, sda, sda_out_out, sda_oe_out;
    logic        busy_out, cmd_valid_out, res_wr_in, res_done_in;
    logic [7:0]  cmd_count_out, opcode_out, first_parameter_out;
    logic [7:0]  cmd_addr_in, cmd_data_out, res_byte_in;
    logic [15:0] second_parameter_out;
    logic [7:0]  g[$];
    int          n_errors, comparisons, n_valid, cycles, n_busy;
    bit          was_busy;
    assign sda = ~((sda_oe_out & ~sda_out_out) | pull);
    command_group_framer #(.TARGET_ADDR(ADDR), .FIFO_DEPTH(16), .BUF_BYTES(155)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sleep_in(sleep_in), .scl_in(scl),
        .sda_in(sda), .sda_out_out(sda_out_out), .sda_oe_out(sda_oe_out),
        .busy_out(busy_out), .cmd_valid_out(cmd_valid_out), .cmd_count_out(cmd_count_out),
        .opcode_out(opcode_out), .first_parameter_out(first_parameter_out),
        .second_parameter_out(second_parameter_out), .cmd_addr_in(cmd_addr_in),
        .cmd_data_out(cmd_data_out), .res_wr_in(res_wr_in), .res_byte_in(res_byte_in),
        .res_done_in(res_done_in));
    host_bus_model host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cmd_valid_out === 1'b1) n_valid++;
        // Error answers end busy before the host has finished its stop
        if (busy_out === 1'b1 && !was_busy) n_busy++;
        was_busy <= (busy_out === 1'b1);
        if (cycles == 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Own reference checksum, kept apart from the design's helper
    function automatic void seal(ref logic [7:0] q[$]);
        logic [15:0] c = 16'h0000;
        foreach (q[k]) for (int i = 0; i < 8; i++)
            c = (q[k][i] ^ c[15]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endfunction : seal
    task automatic addr_phase(input logic rd, input logic exp);
        logic a;
        host.start_bit();
        host.send_byte({ADDR, rd}, a);
        check(16'(a), 16'(exp));
    endtask : addr_phase
    // Host sends the whole group before any read; acks after busy are ignored
    task automatic send_group(input logic [7:0] q[$]);
        logic a;
        addr_phase(1'b0, 1'b1);
        foreach (q[k]) host.send_byte(q[k], a);
        host.stop_bit();
    endtask : send_group
    task automatic read_answer(input logic [7:0] e[$]);
        logic [7:0] b;
        addr_phase(1'b1, 1'b1);
        foreach (e[k]) begin
            host.get_byte(k < e.size() - 1, b);
            check(16'(b), 16'(e[k]));
        end
        host.stop_bit();
    endtask : read_answer
    task automatic wait_busy(input logic lvl);
        int n = 0;
        while (busy_out !== lvl && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        check(16'(busy_out), 16'(lvl));
    endtask : wait_busy
    task automatic t_good();
        int v = n_valid;
        g = {8'h08, 8'h41, 8'h5A, 8'h34, 8'h12, 8'hC3};
        seal(g);
        send_group(g);
        wait_busy(1'b1);
        repeat (3) @(negedge clk_in);
        check(16'(n_valid - v), 16'h0001);
        check({opcode_out, first_parameter_out}, 16'h415A);
        check(second_parameter_out, 16'h1234);
        check(16'(cmd_count_out), 16'h0008);
        cmd_addr_in = 8'h04;
        repeat (2) @(negedge clk_in);
        check(16'(cmd_data_out), 16'h00C3);
        addr_phase(1'b1, 1'b0);
        host.stop_bit();
        res_wr_in = 1'b1;
        res_done_in = 1'b1;
        @(negedge clk_in);
        res_wr_in = 1'b0;
        res_done_in = 1'b0;
        wait_busy(1'b0);
        g = {8'h04, 8'h00};
        seal(g);
        read_answer(g);
    endtask : t_good
    task automatic t_sleep();
        sleep_in = 1'b1;
        @(negedge clk_in);
        sleep_in = 1'b0;
        addr_phase(1'b1, 1'b0);
        host.stop_bit();
    endtask : t_sleep
    // Malformed group: no executor pulse, comm error answer
    task automatic t_bad(input logic [7:0] q[$]);
        int v = n_valid;
        int u = n_busy;
        send_group(q);
        wait_busy(1'b0);
        check(16'(n_busy - u), 16'h0001);
        check(16'(n_valid - v), 16'h0000);
        g = {8'h04, 8'hFF};
        seal(g);
        read_answer(g);
    endtask : t_bad
    initial begin
        {rst_n_in, sleep_in, res_wr_in, res_done_in} = 4'h0;
        {cmd_addr_in, res_byte_in} = 16'h0000;
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_good();
        t_sleep();
        g = {8'h07, 8'h41, 8'h00, 8'h00, 8'h00};
        seal(g);
        g[6] = ~g[6];
        t_bad(g);
        t_bad({8'h03});
        t_bad({8'h9C});
        end_of_test();
    end
endmodule : tb_command_group_framer
